// ===== dma_handshake.sv
`timescale 1ns/1ps
module dma_handshake
#(
    parameter int AW = 8
)
(
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // register bus
    input  wire logic [AW-1:0]          s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [AW-1:0]          s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // system bus pins (asynchronous)
    input  wire logic                   dack_n,
    input  wire logic                   sys_tc,
    input  wire logic                   sys_iord_n,
    input  wire logic                   sys_iowr_n,
    input  wire logic                   sys_wide,
    output logic                        sys_drq,
    // card pins (asynchronous)
    input  wire logic                   sixteen_bit_io_indicator,
    input  wire logic                   audio_led_line,
    input  wire logic                   input_ack_line,
    // controller core, same clock
    input  wire dma_hs_pkg::card_strb_t std_strb,
    input  wire logic                   std_wide,
    input  wire logic                   fifo_empty,
    input  wire logic                   spkr_in,
    input  wire logic                   other_sock_dma,
    // card drive
    output dma_hs_pkg::card_strb_t      card_strb,
    output logic                        card_wide,
    output logic                        spkr_out,
    output logic                        inack_ctl_en
);
    import dma_hs_pkg::*;

    //--------------------------------------------------
    // helpers
    //--------------------------------------------------
    // one decoder shared by write and read paths
    function automatic logic hit(input logic [AW-1:0] a,
                                 input logic [7:0] off);
        hit = (a[7:0] == off);
    endfunction

    function automatic logic mapped(input logic [AW-1:0] a);
        mapped = hit(a, OFF_EXT_CTRL) || hit(a, OFF_IF_CTRL)
              || hit(a, OFF_MISC1)    || hit(a, OFF_MISC2)
              || hit(a, OFF_IOWIN0)   || hit(a, OFF_IOWIN1)
              || hit(a, OFF_STATUS);
    endfunction

    //--------------------------------------------------
    // pin synchronisers
    //--------------------------------------------------
    logic [7:0] s1_r;
    logic [7:0] s2_r;

    // first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= SYNC_RST;
            s2_r <= SYNC_RST;
        end else begin
            s1_r <= {dack_n, sys_tc, sys_iord_n, sys_iowr_n,
                     sixteen_bit_io_indicator, audio_led_line,
                     input_ack_line, sys_wide};
            s2_r <= s1_r;
        end
    end

    logic dack_s_n;
    logic tc_s;
    logic iord_s_n;
    logic iowr_s_n;
    logic io16_s;
    logic audio_s;
    logic inpck_s;
    logic wide_s;
    assign {dack_s_n, tc_s, iord_s_n, iowr_s_n,
            io16_s, audio_s, inpck_s, wide_s} = s2_r;

    //--------------------------------------------------
    // registers
    //--------------------------------------------------
    logic [7:0] ext_ctrl_r;
    logic [7:0] if_ctrl_r;
    logic [7:0] misc1_r;
    logic [7:0] misc2_r;
    logic [7:0] iowin0_r;
    logic [7:0] iowin1_r;

    logic [1:0] req_sel;
    logic       dma_en;
    assign req_sel = ext_ctrl_r[REQ_SEL_HI:REQ_SEL_LO];
    assign dma_en  = misc2_r[DMA_EN_BIT];

    //--------------------------------------------------
    // write channel
    //--------------------------------------------------
    logic          aw_got_r;
    logic          w_got_r;
    logic [AW-1:0] awaddr_r;
    logic [7:0]    wdata_r;
    logic          wen_r;
    logic          wr_go;

    assign wr_go = aw_got_r && w_got_r && !s_axi_bvalid;

    // address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r      <= 1'b0;
            s_axi_awready <= 1'b0;
            awaddr_r      <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r      <= 1'b1;
            s_axi_awready <= 1'b0;
            awaddr_r      <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_got_r      <= 1'b0;
        end else begin
            s_axi_awready <= !aw_got_r && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_r      <= 1'b0;
            s_axi_wready <= 1'b0;
            wdata_r      <= RST_REG;
            wen_r        <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got_r      <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_r      <= s_axi_wdata[7:0];
            wen_r        <= s_axi_wstrb[0]; // only lane 0 is stored
        end else if (wr_go) begin
            w_got_r      <= 1'b0;
        end else begin
            s_axi_wready <= !w_got_r && !s_axi_bvalid;
        end
    end

    // response one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // register stores; status is read only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_ctrl_r <= RST_REG;
            if_ctrl_r  <= RST_REG;
            misc1_r    <= RST_REG;
            misc2_r    <= RST_REG;
            iowin0_r   <= RST_REG;
            iowin1_r   <= RST_REG;
        end else if (wr_go && wen_r) begin
            if (hit(awaddr_r, OFF_EXT_CTRL)) begin
                ext_ctrl_r <= wdata_r;
            end else if (hit(awaddr_r, OFF_IF_CTRL)) begin
                if_ctrl_r  <= wdata_r;
            end else if (hit(awaddr_r, OFF_MISC1)) begin
                misc1_r    <= wdata_r;
            end else if (hit(awaddr_r, OFF_MISC2)) begin
                misc2_r    <= wdata_r;
            end else if (hit(awaddr_r, OFF_IOWIN0)) begin
                iowin0_r   <= wdata_r;
            end else if (hit(awaddr_r, OFF_IOWIN1)) begin
                iowin1_r   <= wdata_r;
            end
        end
    end

    //--------------------------------------------------
    // read channel
    //--------------------------------------------------
    logic [7:0] status;
    logic [7:0] rd_nxt;

    always_comb begin
        rd_nxt = RST_REG;
        if (hit(s_axi_araddr, OFF_EXT_CTRL)) begin
            rd_nxt = ext_ctrl_r;
        end else if (hit(s_axi_araddr, OFF_IF_CTRL)) begin
            rd_nxt = if_ctrl_r;
        end else if (hit(s_axi_araddr, OFF_MISC1)) begin
            rd_nxt = misc1_r;
        end else if (hit(s_axi_araddr, OFF_MISC2)) begin
            rd_nxt = misc2_r;
        end else if (hit(s_axi_araddr, OFF_IOWIN0)) begin
            rd_nxt = iowin0_r;
        end else if (hit(s_axi_araddr, OFF_IOWIN1)) begin
            rd_nxt = iowin1_r;
        end else if (hit(s_axi_araddr, OFF_STATUS)) begin
            rd_nxt = status;
        end
    end

    // arready is pulsed one cycle after arvalid, answer next cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_rvalid) begin
            s_axi_arready <= 1'b0;
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_nxt};
            s_axi_rresp   <= mapped(s_axi_araddr) ? RESP_OKAY
                                                  : RESP_SLVERR;
        end else begin
            s_axi_arready <= s_axi_arvalid;
        end
    end

    //--------------------------------------------------
    // request selection and system request
    //--------------------------------------------------
    logic card_req;
    cyc_t cyc_r;
    cyc_t cyc_nxt;

    // each nonzero select code picks an active-low card pin; zero gives no request
    always_comb begin
        case (req_sel)
            SEL_IO16:  card_req = !io16_s;
            SEL_AUDIO: card_req = !audio_s;
            SEL_INPCK: card_req = !inpck_s;
            default:   card_req = 1'b0;
        endcase
    end

    // the other socket holding the handshake blocks ours
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_drq <= 1'b0;
        end else begin
            sys_drq <= dma_en && card_req && fifo_empty
                    && !other_sock_dma;
        end
    end

    assign status = {3'h0,
                     (req_sel == SEL_IO16) && card_req,
                     dma_en && other_sock_dma,
                     cyc_r != CYC_STD,
                     dma_en && !dack_s_n,
                     sys_drq};

    //--------------------------------------------------
    // card cycle steering
    //--------------------------------------------------
    logic dma_on;

    // no redefinition without a select code and the enable
    assign dma_on = dma_en && (req_sel != SEL_NONE)
                 && !dack_s_n;

    always_comb begin
        case (cyc_r)
            CYC_STD: begin
                if (dma_on && !iord_s_n) begin
                    cyc_nxt = CYC_DWR;
                end else if (dma_on && !iowr_s_n) begin
                    cyc_nxt = CYC_DRD;
                end else begin
                    cyc_nxt = CYC_STD;
                end
            end
            CYC_DWR: cyc_nxt = iord_s_n ? CYC_STD : CYC_DWR;
            CYC_DRD: cyc_nxt = iowr_s_n ? CYC_STD : CYC_DRD;
            default: cyc_nxt = CYC_STD;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cyc_r <= CYC_STD;
        end else begin
            cyc_r <= cyc_nxt;
        end
    end

    // standard strobes pass whenever no DMA cycle is open
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            card_strb <= STRB_IDLE;
            card_wide <= 1'b0;
        end else begin
            case (cyc_nxt)
                CYC_DWR: begin
                    card_strb.reg_n  <= 1'b1;
                    card_strb.oe_n   <= !tc_s;
                    card_strb.we_n   <= 1'b1;
                    card_strb.iord_n <= 1'b0;
                    card_strb.iowr_n <= 1'b1;
                    card_wide        <= wide_s;
                end
                CYC_DRD: begin
                    card_strb.reg_n  <= 1'b1;
                    card_strb.oe_n   <= 1'b1;
                    card_strb.we_n   <= !tc_s;
                    card_strb.iord_n <= 1'b1;
                    card_strb.iowr_n <= 1'b0;
                    card_wide        <= wide_s;
                end
                default: begin
                    card_strb <= std_strb;
                    card_wide <= std_wide;
                end
            endcase
        end
    end

    //--------------------------------------------------
    // pins lost to the request
    //--------------------------------------------------
    // speaker is muted rather than echoing the request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            spkr_out      <= 1'b0;
            inack_ctl_en  <= 1'b0;
        end else begin
            spkr_out      <= spkr_in
                          && (req_sel != SEL_AUDIO);
            inack_ctl_en  <= misc1_r[INACK_CTL_BIT];
        end
    end

endmodule

// ===== dma_hs_pkg.sv
// Functional notes
// - software picks one of three card inputs as request, field bits 7:6
// - select 10 io16 line, 11 audio line, 01 input ack line, low
// - DMA write cycles: output-enable line carries low terminal count
// - DMA read cycles: write-enable line carries low terminal count
// - with io16 line selected, status bit 4 shows request level
// - audio line as request disables speaker output of that socket
// - DMA master enable bit 6 enables DMA and repurposes bus pins
// - system request high only while card request low and FIFO empty
// - system acknowledge low lets device run matching card DMA cycles
// - ordinary card cycles may interleave with DMA cycles
// - zero select field gives standard cycles, no redefinitions
// - card DMA width follows system bus DMA cycle width, 8 or 16
// - only one socket enabled for DMA at a time; other_sock_dma only blocks sys_drq and, with DMA enabled, sets status bit 3
package dma_hs_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_EXT_CTRL  = 8'h00;
    localparam logic [7:0] OFF_IF_CTRL   = 8'h04;
    localparam logic [7:0] OFF_MISC1     = 8'h08;
    localparam logic [7:0] OFF_MISC2     = 8'h0C;
    localparam logic [7:0] OFF_IOWIN0    = 8'h10;
    localparam logic [7:0] OFF_IOWIN1    = 8'h14;
    localparam logic [7:0] OFF_STATUS    = 8'h18;
    // field positions
    localparam int REQ_SEL_HI    = 7;
    localparam int REQ_SEL_LO    = 6;
    localparam int IO_MODE_BIT   = 5;
    localparam int INACK_CTL_BIT = 7;
    localparam int DMA_EN_BIT    = 6;
    localparam int IOWIN_BIT     = 5;
    localparam int ST_DRQ_BIT    = 0;
    localparam int ST_DACK_BIT   = 1;
    localparam int ST_CYC_BIT    = 2;
    localparam int ST_CONF_BIT   = 3;
    localparam int ST_REQ_BIT    = 4;
    // reset values
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] SYNC_RST = 8'hDF;
    // request-select codes
    localparam logic [1:0] SEL_NONE  = 2'h0;
    localparam logic [1:0] SEL_INPCK = 2'h1;
    localparam logic [1:0] SEL_IO16  = 2'h2;
    localparam logic [1:0] SEL_AUDIO = 2'h3;
    // bus response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // card-side strobe bundle, all active low
    typedef struct packed {
        logic reg_n;
        logic oe_n;
        logic we_n;
        logic iord_n;
        logic iowr_n;
    } card_strb_t;

    localparam card_strb_t STRB_IDLE = 5'h1F;

    // card cycle state
    typedef enum logic [1:0] {
        CYC_STD  = 2'b00,
        CYC_DRD  = 2'b01,
        CYC_DWR  = 2'b10
    } cyc_t;
endpackage

// ===== dma_hs_props.sv
`timescale 1ns/1ps
module dma_hs_chk
(
    // clock and reset
    input logic                   aclk,
    input logic                   aresetn,
    // bus answers
    input logic                   s_axi_bvalid,
    input logic                   s_axi_bready,
    input logic                   s_axi_rvalid,
    input logic                   s_axi_rready,
    // system and card pins
    input logic                   sys_tc,
    input logic                   sys_wide,
    input logic                   sys_drq,
    input logic                   sixteen_bit_io_indicator,
    input logic                   audio_led_line,
    input logic                   input_ack_line,
    // core side and card drive
    input dma_hs_pkg::card_strb_t std_strb,
    input logic                   fifo_empty,
    input logic                   other_sock_dma,
    input dma_hs_pkg::card_strb_t card_strb,
    input logic                   card_wide
);
    import dma_hs_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic dma_rd;
    logic dma_wr;
    // a card DMA cycle is reg_n high with an I/O strobe low
    assign dma_rd = card_strb.reg_n & ~card_strb.iord_n;
    assign dma_wr = card_strb.reg_n & ~card_strb.iowr_n;
    // ----------------
    // properties
    // ----------------
    property p_drq_gate;
        sys_drq |-> $past(fifo_empty) && !$past(other_sock_dma);
    endproperty
    a_drq_gate: assert property (p_drq_gate)
        else $error("request raised while blocked");
    property p_drq_pin;
        sys_drq |-> !($past(sixteen_bit_io_indicator, 3)
            && $past(audio_led_line, 3) && $past(input_ack_line, 3));
    endproperty
    a_drq_pin: assert property (p_drq_pin)
        else $error("request raised with no card pin low");
    property p_rd_tc;
        dma_rd |-> card_strb.we_n && card_strb.oe_n == !$past(sys_tc, 3);
    endproperty
    a_rd_tc: assert property (p_rd_tc)
        else $error("card read cycle count line wrong");
    property p_wr_tc;
        dma_wr |-> card_strb.oe_n && card_strb.we_n == !$past(sys_tc, 3);
    endproperty
    a_wr_tc: assert property (p_wr_tc)
        else $error("card write cycle count line wrong");
    property p_wide;
        dma_rd || dma_wr |-> card_wide == $past(sys_wide, 3);
    endproperty
    a_wide: assert property (p_wide)
        else $error("card width differs from system width");
    property p_std;
        !(dma_rd || dma_wr) |-> card_strb == $past(std_strb);
    endproperty
    a_std: assert property (p_std)
        else $error("standard strobes not passed through");
    property p_bdone;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_bdone: assert property (p_bdone)
        else $error("write response repeated");
    property p_rdone;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_rdone: assert property (p_rdone)
        else $error("read response repeated");
    // main scenarios
    c_rd_tc: cover property (dma_rd && !card_strb.oe_n);
    c_wr_tc: cover property (dma_wr && !card_strb.we_n);
    c_drq: cover property ($rose(sys_drq));
endmodule
bind dma_handshake dma_hs_chk u_chk (
    .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
    .s_axi_rready, .sys_tc, .sys_wide, .sys_drq, .sixteen_bit_io_indicator,
    .audio_led_line, .input_ack_line, .std_strb, .fifo_empty,
    .other_sock_dma, .card_strb, .card_wide
);

// ===== dma_hs_far.sv
`timescale 1ns/1ps
module dma_hs_far
(
    // clock and bench control
    input  wire logic                   aclk,
    input  wire logic                   arm,
    input  wire logic                   rd,
    input  wire logic [3:0]             cnt,
    input  wire logic                   wide,
    output logic                        done,
    // system side
    input  wire logic                   sys_drq,
    output logic                        dack_n,
    output logic                        sys_tc,
    output logic                        sys_iord_n,
    output logic                        sys_iowr_n,
    output logic                        sys_wide,
    // card side
    input  wire dma_hs_pkg::card_strb_t card_strb,
    output logic                        card_req_n
);
    import dma_hs_pkg::*;
    // system controller: answer a request, run cnt cycles, tc on last
    initial begin
        card_req_n = 1'b1;
        dack_n = 1'b1;
        sys_tc = 1'b0;
        sys_iord_n = 1'b1;
        sys_iowr_n = 1'b1;
        sys_wide = 1'b0;
        done = 1'b0;
        forever begin
            @(posedge aclk);
            if (arm) begin
                card_req_n <= 1'b0;
                while (!sys_drq) @(posedge aclk);
                dack_n <= 1'b0;
                repeat (4) @(posedge aclk);
                for (int i = 1; i <= cnt; i++) begin
                    sys_wide <= wide;
                    sys_tc <= (i == cnt);
                    if (rd) sys_iowr_n <= 1'b0;
                    else sys_iord_n <= 1'b0;
                    repeat (6) @(posedge aclk);
                    sys_iord_n <= 1'b1;
                    sys_iowr_n <= 1'b1;
                    sys_tc <= 1'b0;
                    sys_wide <= ~wide; // released width line drifts
                    repeat (6) @(posedge aclk);
                end
                dack_n <= 1'b1;
                done <= 1'b1;
                @(posedge aclk);
                done <= 1'b0;
            end
        end
    end
    // card drops its request once its first DMA cycle arrives
    always @(posedge aclk) begin
        if (card_strb.reg_n && !(card_strb.iord_n && card_strb.iowr_n))
            card_req_n <= 1'b1;
    end
endmodule

// ===== tb_isa_pccard_dma_handshake.sv
`timescale 1ns/1ps
module tb_isa_pccard_dma_handshake;
    import dma_hs_pkg::*;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready;
    logic        bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, ncyc, ntc;
    logic [1:0]  bresp, rresp, sel;
    logic        dack_n, sys_tc, sys_iord_n, sys_iowr_n, sys_wide, sys_drq;
    logic        req_n, hold_n, io16, audio, inack, arm, p_rd, p_wide;
    logic        done, fifo_empty, other_sock_dma, card_wide, spkr_out;
    logic        dma_act, dma_q;
    logic [3:0]  p_cnt, std_cnt;
    card_strb_t  std_strb, card_strb;
    int          errors, check_count, cyc;
    // selected pin carries the request; none selected pulls all three
    assign io16 = (sel == SEL_IO16 || sel == SEL_NONE) ? req_n & hold_n : 1'b1;
    assign audio = (sel == SEL_AUDIO || sel == SEL_NONE) ? req_n & hold_n : 1'b1;
    assign inack = (sel == SEL_INPCK || sel == SEL_NONE) ? req_n & hold_n : 1'b1;
    assign dma_act = card_strb.reg_n & ~(card_strb.iord_n & card_strb.iowr_n);
    dma_handshake dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .dack_n(dack_n), .sys_tc(sys_tc),
        .sys_iord_n(sys_iord_n), .sys_iowr_n(sys_iowr_n),
        .sys_wide(sys_wide), .sys_drq(sys_drq),
        .sixteen_bit_io_indicator(io16), .audio_led_line(audio),
        .input_ack_line(inack), .std_strb(std_strb), .std_wide(1'b0),
        .fifo_empty(fifo_empty), .spkr_in(1'b1),
        .other_sock_dma(other_sock_dma), .card_strb(card_strb),
        .card_wide(card_wide), .spkr_out(spkr_out), .inack_ctl_en());
    dma_hs_far far_u (.aclk(aclk), .arm(arm), .rd(p_rd), .cnt(p_cnt),
        .wide(p_wide), .done(done), .sys_drq(sys_drq), .dack_n(dack_n),
        .sys_tc(sys_tc), .sys_iord_n(sys_iord_n), .sys_iowr_n(sys_iowr_n),
        .sys_wide(sys_wide), .card_strb(card_strb), .card_req_n(req_n));
    // clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // background memory reads, paused while a system strobe is low
    always @(posedge aclk) begin
        std_cnt <= std_cnt + 4'h1;
        if (aresetn && std_cnt[2] && sys_iord_n && sys_iowr_n)
            std_strb <= 5'h17;
        else
            std_strb <= STRB_IDLE;
    end
    // count DMA card cycles and those that carry the count mark
    always @(posedge aclk) begin
        dma_q <= dma_act;
        if (dma_act && !dma_q) ncyc <= ncyc + 32'h1;
        if (dma_act && !dma_q && !(card_strb.oe_n && card_strb.we_n))
            ntc <= ntc + 32'h1;
    end
    // hang guard, well above the few hundred cycles the run needs
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors++;
            report_and_stop();
        end
    end
    // ----------------
    // shared tasks
    // ----------------
    task automatic chk(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic drq_is(input logic e, input int n);
        repeat (n) @(posedge aclk);
        chk("sys_drq", {31'h0, e}, {31'h0, sys_drq});
    endtask
    task automatic report_and_stop();
        if (errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0]  r;
        axi_wr(OFF_EXT_CTRL, 32'hC0, r);
        axi_rd(OFF_EXT_CTRL, d, r);
        chk("select field", 32'hC0, d);
        axi_wr(8'h1C, 32'hFF, r);
        chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
        axi_rd(8'h1C, d, r);
        chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r});
    endtask
    task automatic t_off;
        logic [31:0] d0, d1;
        logic [1:0]  r;
        sel <= SEL_NONE;
        hold_n <= 1'b0;
        axi_wr(OFF_EXT_CTRL, 32'h00, r);
        axi_wr(OFF_MISC2, 32'h40, r);
        drq_is(1'b0, 10);
        sel <= SEL_IO16;
        axi_wr(OFF_EXT_CTRL, 32'h80, r);
        axi_wr(OFF_MISC2, 32'h00, r);
        drq_is(1'b0, 10);
        axi_rd(OFF_STATUS, d0, r);
        hold_n <= 1'b1;
        axi_rd(OFF_STATUS, d1, r);
        chk("status level", 32'h1, {31'h0, d0[4] ^ d1[4]});
        chk("speaker", 32'h1, {31'h0, spkr_out});
        hold_n <= 1'b0;
        other_sock_dma <= 1'b1;
        fifo_empty <= 1'b0;
        axi_wr(OFF_MISC2, 32'h40, r);
        drq_is(1'b0, 10);
        other_sock_dma <= 1'b0;
        drq_is(1'b0, 10);
        fifo_empty <= 1'b1;
        drq_is(1'b1, 5);
        hold_n <= 1'b1;
        drq_is(1'b0, 5);
    endtask
    task automatic t_xfer(input logic [1:0] s, input logic rd,
                          input logic [3:0] n, input logic w);
        logic [1:0] r;
        sel <= s;
        axi_wr(OFF_EXT_CTRL, {24'h0, s, 6'h0}, r);
        axi_wr(OFF_IF_CTRL, 32'h20, r);
        axi_wr(OFF_MISC1, 32'h00, r);
        axi_wr(OFF_IOWIN0, 32'h00, r);
        axi_wr(OFF_IOWIN1, 32'h00, r);
        axi_wr(OFF_MISC2, 32'h40, r);
        chk("speaker", {31'h0, s != SEL_AUDIO}, {31'h0, spkr_out});
        ncyc = 32'h0;
        ntc = 32'h0;
        p_rd <= rd;
        p_cnt <= n;
        p_wide <= w;
        arm <= 1'b1;
        @(posedge aclk);
        arm <= 1'b0;
        for (int i = 0; i < 3000 && !done; i++) @(posedge aclk);
        chk("transfer done", 32'h1, {31'h0, done});
        chk("dma cycles", {28'h0, n}, ncyc);
        chk("count cycles", 32'h1, ntc);
        drq_is(1'b0, 0);
    endtask
    // main sequence
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, arm} = 6'h00;
        {awaddr, araddr, wdata} = 48'h0;
        {p_rd, p_wide, p_cnt, std_cnt} = 10'h000;
        {sel, hold_n, fifo_empty, other_sock_dma} = 5'h0C;
        {ncyc, ntc, dma_q} = 65'h0;
        std_strb = STRB_IDLE;
        errors = 0;
        check_count = 0;
        cyc = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_off();
        t_xfer(SEL_INPCK, 1'b0, 4'h3, 1'b0);
        t_xfer(SEL_IO16, 1'b1, 4'h2, 1'b1);
        t_xfer(SEL_AUDIO, 1'b0, 4'h1, 1'b1);
        report_and_stop();
    end
endmodule
